// File: logic/psa_pkg.sv
package psa_pkg;
  // ==========================================
  // widths
  localparam int unsigned data_addr_width = 16;
  localparam int unsigned prog_addr_width = 24;
  localparam int unsigned prog_word_width = 24;
  localparam int unsigned data_word_width = 16;
  localparam int unsigned page_width = 8;
  localparam int unsigned remap_low_bits = 15;
  // ==========================================
  // register map, byte addresses
  localparam logic [7:0] table_page_off = 8'h00;
  localparam logic [7:0] vis_page_off = 8'h04;
  localparam logic [7:0] core_ctrl_off = 8'h08;
  localparam logic [7:0] status_off = 8'h0c;
  localparam int unsigned remap_en_bit = 2;
  localparam int unsigned config_sel_bit = 7;
  localparam logic [7:0] page_reset = 8'h00;
  // ==========================================
  // access kinds
  typedef enum logic [1:0] {acc_data, acc_table, acc_remap} route_type;
endpackage

// File: logic/prog_fetch_reg.sv
`timescale 1ns/1ns
module prog_fetch_reg #(
  parameter int unsigned width = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // capture
  input wire logic load,
  input wire logic [width-1:0] din,
  output logic [width-1:0] dout
);
  // ==========================================
  // registered read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dout <= '0;
    else if (load)
      dout <= din;
  end
endmodule

// File: logic/program_space_address_builder.sv
// What this block does
// - program words are 24 bits wide; data addresses are 16 bits wide
// - table program address is table page above the full 16-bit address
// - each table page selects one 64K-word region
// - table page top bit selects user (0) or configuration (1) memory
// - remap joins visibility page with low 15 address bits, 23-bit address
// - each visibility page selects one 32K-word page
// - remap forces program address bit 23 low, user memory only
// - remap ignores address bit 15; bit 15 comes from page bit 0
// - remapped reads return only the low 16 bits of the program word
// - remap path is read-only; writes never reach program memory
// - table accesses read and write, reaching every byte incl. upper byte
// - remap only when enable bit set and data address top bit is one
// - remapped read adds one cycle: two program memory fetches
// - remap disabled while a table read or write is in progress
`timescale 1ns/1ns
module program_space_address_builder (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // core data access request
  input wire logic acc_valid,
  input wire logic [15:0] acc_addr,
  input wire logic acc_write,
  input wire logic [15:0] acc_wdata,
  input wire logic table_read_op,
  input wire logic table_write_op,
  input wire logic table_high_byte,
  output logic acc_stall,
  output logic acc_done,
  output logic [15:0] acc_rdata,
  // program memory side
  output logic prog_en,
  output logic prog_we,
  output logic [23:0] prog_addr,
  output logic [23:0] prog_wdata,
  output logic [2:0] prog_byte_en,
  output logic prog_config_sel,
  input wire logic [23:0] prog_rdata,
  // data memory side
  output logic data_en,
  output logic data_we,
  output logic [15:0] data_addr,
  output logic [15:0] data_wdata,
  input wire logic [15:0] data_rdata
);
  // ==========================================
  // registers
  logic [7:0] table_page_sel_q;
  logic [7:0] visibility_page_sel_q;
  logic remap_visibility_q;
  logic ap_valid_q;
  logic ap_write_q;
  logic [7:0] ap_addr_q;
  logic table_busy_q;
  logic remap_wait_q;
  logic rd_load;
  logic [15:0] rd_mux;
  logic [15:0] rd_held;
  psa_pkg::route_type route;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end
    else if (hready)
    begin
      ap_valid_q <= hsel && htrans[1];
      ap_write_q <= hwrite;
      ap_addr_q <= haddr[7:0];
    end
  end

  // hsize ignored: only whole-word transfers are used
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      table_page_sel_q <= psa_pkg::page_reset;
      visibility_page_sel_q <= psa_pkg::page_reset;
      remap_visibility_q <= 1'b0;
    end
    else if (ap_valid_q && ap_write_q)
    begin
      case (ap_addr_q)
        psa_pkg::table_page_off: table_page_sel_q <= hwdata[7:0];
        psa_pkg::vis_page_off: visibility_page_sel_q <= hwdata[7:0];
        psa_pkg::core_ctrl_off: remap_visibility_q <= hwdata[psa_pkg::remap_en_bit];
        default: ;
      endcase
    end
  end

  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (ap_valid_q && !ap_write_q)
    begin
      case (ap_addr_q)
        psa_pkg::table_page_off: hrdata = {24'h000000, table_page_sel_q};
        psa_pkg::vis_page_off: hrdata = {24'h000000, visibility_page_sel_q};
        psa_pkg::core_ctrl_off: hrdata[psa_pkg::remap_en_bit] = remap_visibility_q;
        psa_pkg::status_off: hrdata = {30'h0, remap_wait_q, table_busy_q};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // route selection
  logic table_req;
  assign table_req = table_read_op || table_write_op;
  always_comb
  begin
    if (acc_valid && table_req)
      route = psa_pkg::acc_table;
    // table activity masks the remap window
    else if (acc_valid && remap_visibility_q && acc_addr[15] && !table_busy_q)
      route = psa_pkg::acc_remap;
    else
      route = psa_pkg::acc_data;
  end

  // table_busy marks a table op in flight so a following remap is held off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      table_busy_q <= 1'b0;
    else
      table_busy_q <= acc_valid && table_req;
  end

  // ==========================================
  // remap: two fetches, extra cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      remap_wait_q <= 1'b0;
    else if (remap_wait_q)
      remap_wait_q <= 1'b0;
    else
      remap_wait_q <= (route == psa_pkg::acc_remap) && !acc_write;
  end

  // stall in first remap read cycle; done on the second
  assign acc_stall = (route == psa_pkg::acc_remap) && !acc_write && !remap_wait_q;
  assign acc_done = acc_valid && !acc_stall;

  // ==========================================
  // address formation
  always_comb
  begin
    prog_en = 1'b0;
    prog_we = 1'b0;
    prog_addr = 24'h000000;
    prog_wdata = 24'h000000;
    prog_byte_en = 3'h0;
    prog_config_sel = 1'b0;
    data_en = 1'b0;
    data_we = 1'b0;
    data_addr = acc_addr;
    data_wdata = acc_wdata;
    case (route)
      psa_pkg::acc_table:
      begin
        prog_en = 1'b1;
        prog_addr = {table_page_sel_q, acc_addr};
        prog_config_sel = table_page_sel_q[psa_pkg::config_sel_bit];
        prog_we = table_write_op;
        if (table_high_byte)
        begin
          prog_byte_en = 3'h4;
          prog_wdata = {acc_wdata[7:0], 16'h0000};
        end
        else
        begin
          prog_byte_en = 3'h3;
          prog_wdata = {8'h00, acc_wdata};
        end
      end
      psa_pkg::acc_remap:
      begin
        // remap writes are dropped, never routed anywhere
        prog_en = !acc_write;
        prog_we = 1'b0;
        prog_addr = {1'b0, visibility_page_sel_q, acc_addr[14:0]};
        prog_byte_en = 3'h3;
      end
      psa_pkg::acc_data:
      begin
        data_en = acc_valid;
        data_we = acc_valid && acc_write;
      end
      default: ;
    endcase
  end

  // ==========================================
  // read data return
  always_comb
  begin
    rd_mux = data_rdata;
    if (route == psa_pkg::acc_remap)
      rd_mux = prog_rdata[15:0];
    else if (route == psa_pkg::acc_table && table_high_byte)
      rd_mux = {8'h00, prog_rdata[23:16]};
    else if (route == psa_pkg::acc_table)
      rd_mux = prog_rdata[15:0];
  end
  assign rd_load = acc_done && !acc_write;

  prog_fetch_reg #(
    .width(psa_pkg::data_word_width)
  ) u_rd (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(rd_load),
    .din(rd_mux),
    .dout(rd_held)
  );
  assign acc_rdata = rd_held;

  // ==========================================
  // checks
  a_remap_user_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_remap) |-> !prog_addr[23])
    else $error("remap reached configuration memory");
  a_remap_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_remap) |-> !prog_we)
    else $error("remap path wrote program memory");
  a_remap_addr_form: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_remap && !acc_write)
      |-> prog_addr[22:0] == {visibility_page_sel_q, acc_addr[14:0]})
    else $error("remap address wrong");
  a_table_addr_form: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_table) |-> prog_addr == {table_page_sel_q, acc_addr})
    else $error("table address wrong");
  a_table_cfg_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_table)
      |-> prog_config_sel == table_page_sel_q[psa_pkg::config_sel_bit])
    else $error("config select wrong");
  a_remap_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_remap) |-> remap_visibility_q && acc_addr[15])
    else $error("remap without enable");
  a_remap_after_tbl: assert property (@(posedge hclk) disable iff (!hresetn)
    table_busy_q |-> route != psa_pkg::acc_remap)
    else $error("remap during table op");
  a_remap_extra_cyc: assert property (@(posedge hclk) disable iff (!hresetn)
    acc_stall |=> !acc_stall && (acc_done || !acc_valid))
    else $error("remap stall not one cycle");
  a_remap_rdata: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_remap && acc_done && !acc_write) |=> acc_rdata == $past(prog_rdata[15:0]))
    else $error("remap read data wrong");
  a_data_route: assert property (@(posedge hclk) disable iff (!hresetn)
    (acc_valid && !acc_addr[15] && !table_req) |-> data_en && !prog_en)
    else $error("low address not to data memory");
  a_table_hi_bytes: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_table && table_high_byte) |-> prog_byte_en == 3'h4)
    else $error("upper byte lane not selected");
  a_table_hi_data: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_table && table_high_byte) |-> prog_wdata[23:16] == acc_wdata[7:0])
    else $error("upper byte write data misplaced");
  a_table_lo_data: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_table && !table_high_byte)
      |-> prog_byte_en == 3'h3 && prog_wdata[15:0] == acc_wdata)
    else $error("low word write lanes wrong");
  a_table_write_en: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_table) |-> prog_en && prog_we == table_write_op)
    else $error("table write enable wrong");
  a_table_rd_hi: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_table && table_high_byte && acc_done && !acc_write)
      |=> acc_rdata == {8'h00, $past(prog_rdata[23:16])})
    else $error("upper byte read data wrong");
  a_table_rd_lo: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_table && !table_high_byte && acc_done && !acc_write)
      |=> acc_rdata == $past(prog_rdata[15:0]))
    else $error("table low word read data wrong");
  a_table_no_data: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_table) |-> !data_en && !data_we)
    else $error("table access reached data memory");
  a_table_region: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_table) |-> prog_addr[23:16] == table_page_sel_q)
    else $error("table region not from page");
  a_remap_no_data: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_remap) |-> !data_en && !data_we)
    else $error("remap access reached data memory");
  a_remap_wr_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_remap && acc_write) |-> !prog_en && acc_done)
    else $error("remap write not dropped");
  a_remap_page_hi: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_remap && !acc_write) |-> prog_addr[22:15] == visibility_page_sel_q)
    else $error("remap page field wrong");
  a_remap_page_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_remap && !acc_write) |-> prog_addr[15] == visibility_page_sel_q[0])
    else $error("remap bit 15 not from page");
  a_remap_cfg_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_remap) |-> !prog_config_sel)
    else $error("remap selected configuration memory");
  a_remap_stall_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_remap && !acc_write && !remap_wait_q) |-> acc_stall && !acc_done)
    else $error("remap read not stalled");
  a_remap_wait_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    remap_wait_q |=> !remap_wait_q)
    else $error("remap wait longer than one cycle");
  a_remap_off_data: assert property (@(posedge hclk) disable iff (!hresetn)
    (acc_valid && !remap_visibility_q && !table_req) |-> data_en && !prog_en)
    else $error("remap while disabled");
  a_table_busy_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (acc_valid && table_req) |=> table_busy_q)
    else $error("table busy not marked");
  a_data_no_prog: assert property (@(posedge hclk) disable iff (!hresetn)
    (route == psa_pkg::acc_data) |-> !prog_en && !prog_we)
    else $error("data access reached program memory");
  a_data_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    data_en |-> data_addr == acc_addr && data_wdata == acc_wdata)
    else $error("data request altered");
  a_idle_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    !acc_valid |-> !prog_en && !data_en && !acc_done)
    else $error("memory request without access");
  a_table_page_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    (ap_valid_q && ap_write_q && ap_addr_q == psa_pkg::table_page_off)
      |=> table_page_sel_q == $past(hwdata[7:0]))
    else $error("table page write lost");
  a_vis_page_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    (ap_valid_q && ap_write_q && ap_addr_q == psa_pkg::vis_page_off)
      |=> visibility_page_sel_q == $past(hwdata[7:0]))
    else $error("visibility page write lost");
  a_remap_en_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    (ap_valid_q && ap_write_q && ap_addr_q == psa_pkg::core_ctrl_off)
      |=> remap_visibility_q == $past(hwdata[psa_pkg::remap_en_bit]))
    else $error("remap enable write lost");
endmodule

// File: test/mem_model.sv
`timescale 1ns/1ns
// ==========================================
// program and data memory, same-cycle read
module mem_model (
  // clock
  input wire logic hclk,
  // program side
  input wire logic prog_en,
  input wire logic [23:0] prog_addr,
  output logic [23:0] prog_rdata,
  // data side
  input wire logic data_en,
  input wire logic [15:0] data_addr,
  output logic [15:0] data_rdata
);
  logic flip_q;
  initial flip_q = 1'b0;
  // unselected lines toggle so a stale word never matches
  always @(posedge hclk)
    flip_q <= !flip_q;
  assign prog_rdata = prog_en ? {~prog_addr[23:16], prog_addr[15:0] ^ 16'h5a3c} : {24{flip_q}};
  assign data_rdata = data_en ? data_addr ^ 16'hc33c : {16{flip_q}};
endmodule

// File: test/tb.sv
`timescale 1ns/1ns
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hwrite = 1'b0, hreadyout, hresp, rd_ph = 1'b0, stall_q = 1'b0, rd_pend = 1'b0;
  logic acc_valid = 1'b0, acc_write = 1'b0, table_read_op = 1'b0, table_write_op = 1'b0;
  logic table_high_byte = 1'b0, acc_stall, acc_done, prog_en, prog_we, prog_config_sel;
  logic data_en, data_we;
  logic [15:0] acc_addr = 16'h0, acc_wdata = 16'h0, acc_rdata, data_addr, data_wdata, data_rdata;
  logic [23:0] prog_addr, prog_wdata, prog_rdata;
  logic [2:0] prog_byte_en;
  logic [31:0] exp_q[$];
  logic [31:0] acc_view;
  logic [7:0] lfsr = 8'h1a, tp, tc, vp;
  logic [15:0] a;
  int mismatches = 0, n_compared = 0, cycles = 0;
  // ==========================================
  // clock, parts
  always #50 hclk = !hclk;
  program_space_address_builder dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .acc_valid, .acc_addr,
    .acc_write, .acc_wdata, .table_read_op, .table_write_op, .table_high_byte, .acc_stall,
    .acc_done, .acc_rdata, .prog_en, .prog_we, .prog_addr, .prog_wdata, .prog_byte_en,
    .prog_config_sel, .prog_rdata, .data_en, .data_we, .data_addr, .data_wdata, .data_rdata);
  mem_model mem (.hclk, .prog_en, .prog_addr, .prog_rdata, .data_en, .data_addr, .data_rdata);
  assign acc_view = (acc_write && !prog_we && !data_we) ? 32'h0 : {prog_we, data_we, prog_en,
    data_en, prog_config_sel && prog_en, prog_we ? prog_byte_en : {acc_stall, 2'b0},
    prog_en ? prog_addr : {8'h0, data_addr}};
  // ==========================================
  // helpers
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  task automatic conclude;
    if (exp_q.size() != 0)
    begin
      mismatches++;
      $display("unexpected at %0t: %0d expected results never seen", $time, exp_q.size());
    end
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got);
    logic [31:0] e;
    e = exp_q.pop_front();
    n_compared++;
    if (got !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, e);
    end
  endtask
  // wait on hreadyout (s=0) or acc_done (s=1); only the timeout ends a hang
  task automatic wt(input bit s);
    @(posedge hclk);
    while ((s ? acc_done : hreadyout) !== 1'b1)
      @(posedge hclk);
  endtask
  task automatic ahb(input logic [7:0] ad, input logic wr, input logic [31:0] wd, ev);
    acc_valid <= 1'b0;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    htrans <= 2'h2;
    if (!wr)
      exp_q.push_back(ev);
    wt(0);
    htrans <= 2'h0;
    hwdata <= wd;
    wt(0);
  endtask
  // k = {write, table op, high byte}; ed = first-cycle view, er = read or written word
  task automatic acc(input logic [15:0] ad, input logic [2:0] k, input logic [31:0] ed, er);
    acc_valid <= 1'b1;
    acc_addr <= ad;
    acc_write <= k[2];
    table_read_op <= k[1] && !k[2];
    table_write_op <= k[1] && k[2];
    table_high_byte <= k[0];
    acc_wdata <= ~ad;
    exp_q.push_back(ed);
    exp_q.push_back(er);
    wt(1);
  endtask
  task automatic idle;
    acc_valid <= 1'b0;
    @(posedge hclk);
  endtask
  // ==========================================
  // watcher: takes the oldest note at each result
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout)
      chk(hrdata | {hresp, 31'h0});
    if (hreadyout)
      rd_ph <= htrans[1] && !hwrite;
    if (rd_pend)
      chk({16'h0, acc_rdata});
    rd_pend <= acc_done && !acc_write;
    if (acc_valid && !stall_q)
      chk(acc_view);
    if (acc_valid && acc_write)
      chk(prog_we ? {8'h0, prog_wdata} : (data_we ? {16'h0, data_wdata} : 32'h0));
    stall_q <= acc_valid && acc_stall;
  end
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles > 2000)
    begin
      mismatches++;
      $display("unexpected at %0t: run timed out", $time);
      conclude();
    end
  end
  // ==========================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(8'h00, 0, 0, 0);
    ahb(8'h04, 0, 0, 0);
    ahb(8'h08, 0, 0, 0);
    tp = rnd() & 8'h7f;
    tc = tp | 8'h80;
    vp = rnd();
    ahb(8'h00, 1, {24'h0, tp}, 0);
    ahb(8'h04, 1, {24'h0, vp}, 0);
    ahb(8'h08, 1, 32'h4, 0);
    ahb(8'h00, 0, 0, {24'h0, tp});
    ahb(8'h04, 0, 0, {24'h0, vp});
    ahb(8'h10, 1, 32'hffff_ffff, 0);
    ahb(8'h10, 0, 0, 0);
    a = {rnd(), rnd()};
    acc(a, 3'b010, {8'h20, tp, a}, {16'h0, a ^ 16'h5a3c});
    acc(a, 3'b111, {8'ha4, tp, a}, {8'h0, ~a[7:0], 16'h0});
    acc(a, 3'b110, {8'ha3, tp, a}, {16'h0, ~a});
    acc(a, 3'b011, {8'h20, tp, a}, {24'h0, ~tp});
    ahb(8'h00, 1, {24'h0, tc}, 0);
    acc(a, 3'b010, {8'h28, tc, a}, {16'h0, a ^ 16'h5a3c});
    repeat (3)
    begin
      idle();
      a = {rnd(), rnd()} | 16'h8000;
      acc(a, 3'b000, {8'h24, 1'b0, vp, a[14:0]}, {16'h0, {vp[0], a[14:0]} ^ 16'h5a3c});
    end
    acc(a, 3'b100, 0, 0);
    acc(a, 3'b010, {8'h28, tc, a}, {16'h0, a ^ 16'h5a3c});
    acc(a, 3'b000, {8'h10, 8'h0, a}, {16'h0, a ^ 16'hc33c});
    ahb(8'h08, 1, 0, 0);
    idle();
    acc(a, 3'b000, {8'h10, 8'h0, a}, {16'h0, a ^ 16'hc33c});
    ahb(8'h08, 1, 32'h4, 0);
    a = a & 16'h7fff;
    acc(a, 3'b100, {8'h50, 8'h0, a}, {16'h0, ~a});
    acc(a, 3'b000, {8'h10, 8'h0, a}, {16'h0, a ^ 16'hc33c});
    idle();
    idle();
    conclude();
  end
endmodule
